// ### src/psw_watchdog.sv
// Purpose: Watchdog supervisor; pulses an active-low output when the strobe stops toggling.
// Assumes: Strobe and select pins are asynchronous; one free-running clock; sync reset.
// Notes: Variant and output pulse width are fixed at build time by parameters.
`timescale 1ns/1ps

// Overview of operation
// - Output pulse fires when strobe stays constant for the whole timeout period.
// - Timeout counter clears on every strobe edge and when the pulse asserts.
// - Output stays high while strobed in time; goes low for pulse width on expiry.
// - Pulse width is 100ms open-drain or 1ms push-pull, chosen by parameter.
// - Startup delay and timeout come from variant plus three-bit select code.
// - Equal-timing variant: startup equals timeout, 1ms up to 60s by code.
// - Fixed-startup variant: 60s startup, timeouts 1ms up to 60s by code.
// - Third variant: startup and timeout pairs per code, 30us to 60s.
// - Third variant codes 101 and 110 wait for first strobe edge.
// - Startup delay begins at power-up and on any select input change.
// - No counting and no pulses during the startup delay.
// - After startup, normal timeout counting and strobe monitoring begin.
// - Code 011 disables the watchdog; another code re-enables it.
// - Strobe edges ignored during the pulse and the startup delay.
// - A 300us settle interval ignores the strobe before startup begins.
// - Timing restarts from zero when the output pulse ends.
module psw_watchdog #(
	parameter psw_pkg::psw_variant_t VARIANT = psw_pkg::PSW_VAR_EQUAL,
	parameter bit OPEN_DRAIN = 1'b1,
	parameter int unsigned TICK_CYCLES = psw_pkg::PSW_TICK_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic strobe_in,
	input wire logic timing_select_0,
	input wire logic timing_select_1,
	input wire logic timing_select_2,
	output logic timeout_pulse_n
);
	import psw_pkg::*;

	// Refuse tick lengths the prescaler cannot count
	if (TICK_CYCLES < 1 || TICK_CYCLES > (1 << PSW_PRE_W)) begin : g_bad_tick
		$error("TICK_CYCLES out of range for the prescaler");
	end

	localparam logic [PSW_CW-1:0] PULSE_TICKS =
		psw_ticks(OPEN_DRAIN ? PSW_PULSE_OD_US : PSW_PULSE_PP_US);
	localparam logic [PSW_PRE_W-1:0] TICK_LAST = PSW_PRE_W'(TICK_CYCLES - 1);

	psw_regs_t r;
	psw_regs_t n;
	logic tick;
	logic strobeEdge;
	logic selChanged;
	logic firstEdgeCode;
	logic [PSW_CW-1:0] timeoutTicks;
	logic [PSW_CW-1:0] startupTicks;

	// Timeout period for a select code in this variant
	function automatic logic [PSW_CW-1:0] timeoutFor(input logic [2:0] code);
		logic [PSW_CW-1:0] t;
		t = '0;
		unique case (code)
			3'h0: t = (VARIANT == PSW_VAR_FIRST) ? psw_ticks(PSW_3MS) : psw_ticks(PSW_1MS);
			3'h1: begin
				if (VARIANT == PSW_VAR_EQUAL) begin
					t = psw_ticks(PSW_10MS);
				end else if (VARIANT == PSW_VAR_FIXED) begin
					t = psw_ticks(PSW_3MS);
				end else begin
					t = psw_ticks(PSW_3S);
				end
			end
			3'h2: begin
				if (VARIANT == PSW_VAR_EQUAL) begin
					t = psw_ticks(PSW_30MS);
				end else if (VARIANT == PSW_VAR_FIXED) begin
					t = psw_ticks(PSW_10MS);
				end else begin
					t = psw_ticks(PSW_1S);
				end
			end
			3'h3: t = '0;
			3'h4: t = (VARIANT == PSW_VAR_FIRST) ? psw_ticks(PSW_30US) : psw_ticks(PSW_100MS);
			3'h5: t = (VARIANT == PSW_VAR_FIXED) ? psw_ticks(PSW_300MS) : psw_ticks(PSW_1S);
			3'h6: t = (VARIANT == PSW_VAR_FIXED) ? psw_ticks(PSW_3S) : psw_ticks(PSW_10S);
			3'h7: t = (VARIANT == PSW_VAR_FIRST) ? psw_ticks(PSW_10S) : psw_ticks(PSW_60S);
		endcase
		return t;
	endfunction : timeoutFor

	// Startup delay for a select code in this variant
	function automatic logic [PSW_CW-1:0] startupFor(input logic [2:0] code);
		logic [PSW_CW-1:0] s;
		s = timeoutFor(code);
		if (VARIANT == PSW_VAR_FIXED) begin
			s = psw_ticks(PSW_60S);
		end else if (VARIANT == PSW_VAR_FIRST) begin
			unique case (code)
				3'h0: s = psw_ticks(PSW_3MS);
				3'h1: s = psw_ticks(PSW_3S);
				3'h2: s = psw_ticks(PSW_60S);
				3'h4: s = psw_ticks(PSW_200US);
				3'h7: s = psw_ticks(PSW_60S);
				default: s = '0;
			endcase
		end
		return s;
	endfunction : startupFor

	// Decoded timing of the held setting
	assign timeoutTicks = timeoutFor(r.selHeld);
	assign startupTicks = startupFor(r.selHeld);
	assign firstEdgeCode = (VARIANT == PSW_VAR_FIRST) &&
		(r.selHeld == PSW_SEL_EDGE_A || r.selHeld == PSW_SEL_EDGE_B);

	// Edge and change detection on the second sync stage only
	assign strobeEdge = r.strobeSync[1] ^ r.strobePrev;
	assign selChanged = r.selSync != r.selHeld;
	assign tick = r.prescale == TICK_LAST;

	// Next-state logic
	always_comb begin
		n = r;
		// Two-stage synchronisers
		n.strobeSync = {r.strobeSync[0], strobe_in};
		n.strobePrev = r.strobeSync[1];
		n.selMeta = {timing_select_2, timing_select_1, timing_select_0};
		n.selSync = r.selMeta;
		// Prescaler and tick counter
		n.prescale = tick ? '0 : r.prescale + 1'b1;
		if (tick) begin
			n.count = r.count + 1'b1;
		end
		unique case (r.state)
			PSW_SETTLE: begin
				// Strobe ignored while the setting settles
				if (tick && r.count == PSW_SETTLE_TICKS - 1'b1) begin
					n.count = '0;
					n.prescale = '0;
					if (r.selHeld == PSW_SEL_DISABLE) begin
						n.state = PSW_DISABLED;
					end else if (firstEdgeCode) begin
						n.state = PSW_FIRSTEDGE;
					end else begin
						n.state = PSW_STARTUP;
					end
				end
			end
			PSW_STARTUP: begin
				// Edges ignored, output held high
				if (tick && r.count == startupTicks - 1'b1) begin
					n.state = PSW_RUN;
					n.count = '0;
					n.prescale = '0;
				end
			end
			PSW_FIRSTEDGE: begin
				// No timer; first strobe edge ends startup
				n.count = '0;
				n.prescale = '0;
				if (strobeEdge) begin
					n.state = PSW_RUN;
				end
			end
			PSW_RUN: begin
				if (strobeEdge) begin
					n.count = '0;
					n.prescale = '0;
				end else if (tick && r.count == timeoutTicks - 1'b1) begin
					n.state = PSW_PULSE;
					n.outN = 1'b0;
					n.count = '0;
					n.prescale = '0;
				end
			end
			PSW_PULSE: begin
				// Strobe ignored while the output is low
				if (tick && r.count == PULSE_TICKS - 1'b1) begin
					n.outN = 1'b1;
					n.count = '0;
					n.prescale = '0;
					n.changePending = 1'b0;
					n.state = r.changePending ? PSW_SETTLE : PSW_RUN;
				end
			end
			PSW_DISABLED: begin
				n.count = '0;
				n.prescale = '0;
			end
		endcase
		// A new setting restarts from the settle interval
		if (selChanged) begin
			n.selHeld = r.selSync;
			// Only a pulse already on the pin finishes first; an expiry this cycle yields
			if (r.state == PSW_PULSE && n.state == PSW_PULSE) begin
				n.changePending = 1'b1;
			end else begin
				n.state = PSW_SETTLE;
				n.count = '0;
				n.prescale = '0;
				n.outN = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			r <= PSW_RESET;
		end else begin
			r <= n;
		end
	end

	assign timeout_pulse_n = r.outN;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_run_expire;
		r.state == PSW_RUN && !strobeEdge && tick && r.count == timeoutTicks - 1'b1 && !selChanged;
	endsequence
	sequence s_start_done;
		r.state == PSW_STARTUP && tick && r.count == startupTicks - 1'b1 && !selChanged;
	endsequence

	property p_expire;
		s_run_expire |=> !timeout_pulse_n && r.count == '0 && r.state == PSW_PULSE;
	endproperty
	a_expire: assert property (p_expire) else $error("timeout did not start a pulse");

	property p_edge_clear;
		r.state == PSW_RUN && strobeEdge && !selChanged |=> r.count == '0 && r.prescale == '0;
	endproperty
	a_edge_clear: assert property (p_edge_clear) else $error("strobe edge did not clear");

	property p_low_pulse;
		!timeout_pulse_n |-> r.state == PSW_PULSE;
	endproperty
	a_low_pulse: assert property (p_low_pulse) else $error("output low outside pulse");

	property p_width;
		$rose(timeout_pulse_n) |-> $past(r.count) == PULSE_TICKS - 1'b1 && $past(tick);
	endproperty
	a_width: assert property (p_width) else $error("pulse width wrong");

	property p_quiet;
		r.state inside {PSW_SETTLE, PSW_STARTUP, PSW_FIRSTEDGE, PSW_DISABLED} |-> timeout_pulse_n;
	endproperty
	a_quiet: assert property (p_quiet) else $error("output low during startup");

	property p_start_done;
		s_start_done |=> r.state == PSW_RUN && r.count == '0;
	endproperty
	a_start_done: assert property (p_start_done) else $error("startup did not end");

	property p_sel_change;
		selChanged && r.state != PSW_PULSE |=> r.state == PSW_SETTLE && r.count == '0;
	endproperty
	a_sel_change: assert property (p_sel_change) else $error("setting change missed");

	property p_disabled;
		r.state == PSW_DISABLED |-> r.selHeld == PSW_SEL_DISABLE && timeout_pulse_n;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled with wrong code");

	property p_ignore;
		r.state == PSW_STARTUP && strobeEdge && !selChanged &&
			!(tick && r.count == startupTicks - 1'b1) |=>
			r.state == PSW_STARTUP && r.count == $past(r.count) + $past(tick);
	endproperty
	a_ignore: assert property (p_ignore) else $error("edge acted in startup");

	property p_restart;
		$rose(timeout_pulse_n) |-> r.count == '0 && r.state inside {PSW_RUN, PSW_SETTLE};
	endproperty
	a_restart: assert property (p_restart) else $error("no restart after pulse");
endmodule : psw_watchdog

// ### shared/psw_pkg.sv
// Purpose: Constants, state encoding and register layout of the pin-selectable watchdog.
// Assumes: A free-running 20 MHz clock and a 10 us timing tick derived from it.
// Notes: All intervals are held in microseconds and converted to whole ticks, rounded up.
package psw_pkg;
	// Clock and tick
	localparam int unsigned PSW_CLOCK_HZ = 20_000_000;
	localparam int unsigned PSW_TICK_US = 10;
	localparam int unsigned PSW_TICK_CYCLES = PSW_TICK_US * (PSW_CLOCK_HZ / 1_000_000);
	localparam int unsigned PSW_PRE_W = 16;
	localparam int unsigned PSW_CW = 23;

	// Interval minimums in microseconds
	localparam longint PSW_30US = 30;
	localparam longint PSW_200US = 200;
	localparam longint PSW_SETTLE_US = 300;
	localparam longint PSW_1MS = 1_000;
	localparam longint PSW_3MS = 3_000;
	localparam longint PSW_10MS = 10_000;
	localparam longint PSW_30MS = 30_000;
	localparam longint PSW_100MS = 100_000;
	localparam longint PSW_300MS = 300_000;
	localparam longint PSW_1S = 1_000_000;
	localparam longint PSW_3S = 3_000_000;
	localparam longint PSW_10S = 10_000_000;
	localparam longint PSW_60S = 60_000_000;
	localparam longint PSW_PULSE_OD_US = 100_000;
	localparam longint PSW_PULSE_PP_US = 1_000;

	// Microseconds to whole ticks, never shorter than asked
	function automatic logic [PSW_CW-1:0] psw_ticks(input longint us);
		return PSW_CW'((us + PSW_TICK_US - 1) / PSW_TICK_US);
	endfunction : psw_ticks

	localparam logic [PSW_CW-1:0] PSW_SETTLE_TICKS = psw_ticks(PSW_SETTLE_US);

	// Select codes with special meaning
	localparam logic [2:0] PSW_SEL_DISABLE = 3'h3;
	localparam logic [2:0] PSW_SEL_EDGE_A = 3'h5;
	localparam logic [2:0] PSW_SEL_EDGE_B = 3'h6;

	typedef enum {PSW_VAR_EQUAL, PSW_VAR_FIXED, PSW_VAR_FIRST} psw_variant_t;

	typedef enum logic [2:0] {
		PSW_SETTLE, PSW_STARTUP, PSW_FIRSTEDGE, PSW_RUN, PSW_PULSE, PSW_DISABLED
	} psw_state_t;

	typedef struct packed {
		logic [1:0] strobeSync;
		logic strobePrev;
		logic [2:0] selMeta;
		logic [2:0] selSync;
		logic [2:0] selHeld;
		logic changePending;
		logic [PSW_PRE_W-1:0] prescale;
		logic [PSW_CW-1:0] count;
		psw_state_t state;
		logic outN;
	} psw_regs_t;

	localparam psw_regs_t PSW_RESET = '{
		strobeSync: 2'h0, strobePrev: 1'b0, selMeta: 3'h0, selSync: 3'h0, selHeld: 3'h0,
		changePending: 1'b0, prescale: '0, count: '0, state: PSW_SETTLE, outN: 1'b1
	};
endpackage : psw_pkg

// ### tb/psw_host_model.sv
// Purpose: Host model that keeps the watchdog strobe toggling.
// Assumes: Gaps are random, from 2 up to maxGap + 1 cycles.
// Notes: Reports the cycle of its latest strobe change.
`timescale 1ns/1ps
module psw_host_model (
	input wire logic clock,
	input wire logic enable,
	input wire logic [31:0] maxGap,
	input wire logic [31:0] cyc,
	output logic strobeOut,
	output logic [31:0] lastEdge
);
	int seed = 95;
	int waitLeft = 0;
	initial strobeOut = 1'b0;
	initial lastEdge = 32'h0;
	// Toggle after a random gap shorter than the timeout
	always @(negedge clock) begin
		if (enable && waitLeft <= 0) begin
			strobeOut <= ~strobeOut;
			lastEdge <= cyc;
			waitLeft <= 1 + int'($unsigned($random(seed)) % maxGap);
		end else begin
			waitLeft <= waitLeft - 1;
		end
	end
endmodule : psw_host_model

// ### tb/test_pin_selectable_watchdog_supervisor.sv
// Purpose: Self-checking bench for the watchdog, third variant, short pulse.
// Assumes: One clock per tick, so every interval is counted in clocks.
// Notes: Pulse edges are queued; falls are checked against windows from the timing table, rises against the fixed PULSE width.
`timescale 1ns/1ps
module test_pin_selectable_watchdog_supervisor;
	import psw_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] sel = 3'h0;
	logic hostOn = 1'b0;
	logic [31:0] gap = 32'h64;
	logic [31:0] cyc = 32'h0;
	logic [31:0] lastEdge;
	logic strobe;
	logic pulseN;
	logic pulsePrev = 1'b1;
	int nErrors = 0;
	int checked = 0;
	int fallQ[$];
	int riseQ[$];
	int stT[8] = '{300, 300000, 6000000, 0, 20, 0, 0, 6000000};
	int toT[8] = '{300, 300000, 100000, 0, 3, 100000, 1000000, 1000000};
	localparam int SETTLE = 30;
	localparam int PULSE = 100;
	localparam int LAT = 8;

	psw_watchdog #(.VARIANT(PSW_VAR_FIRST), .OPEN_DRAIN(1'b0), .TICK_CYCLES(1)) psw_watchdog_i (
		.clock(clock), .reset_n(reset_n), .strobe_in(strobe), .timing_select_0(sel[0]),
		.timing_select_1(sel[1]), .timing_select_2(sel[2]), .timeout_pulse_n(pulseN));
	psw_host_model psw_host_model_i (.clock(clock), .enable(hostOn), .maxGap(gap),
		.cyc(cyc), .strobeOut(strobe), .lastEdge(lastEdge));

	// Clock and cycle count
	always #25 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 32'h1;
	// Record output edges, sampled away from the launching clock edge
	always @(negedge clock) begin
		if (pulsePrev && !pulseN) begin
			fallQ.push_back(int'(cyc));
		end
		if (!pulsePrev && pulseN) begin
			riseQ.push_back(int'(cyc));
		end
		pulsePrev <= pulseN;
	end

	task automatic wrapUp();
		$display("checks made %0d errors %0d", checked, nErrors);
		if (nErrors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrapUp

	task automatic check(string name, int exp, int got);
		checked++;
		if (got !== exp) begin
			nErrors++;
			$display("wrong value %s expected %0d seen %0d", name, exp, got);
		end
	endtask : check

	task automatic checkIn(string name, int lo, int hi, int got);
		checked++;
		if (got < lo || got > hi) begin
			nErrors++;
			$display("wrong value %s expected %0d to %0d seen %0d", name, lo, hi, got);
		end
	endtask : checkIn

	// Bounded wait for the next queued edge
	task automatic waitEdge(ref int q[$], input int bound, output int t);
		for (int i = 0; i < bound && q.size() == 0; i++) @(posedge clock);
		if (q.size() == 0) begin
			nErrors++;
			$display("wrong value output edge expected edge seen none");
			wrapUp();
		end else begin
			t = q.pop_front();
		end
	endtask : waitEdge

	task automatic setSel(input logic [2:0] code, output int tc);
		@(negedge clock);
		sel = code;
		tc = int'(cyc);
	endtask : setSel

	task automatic quiet(string name, int n);
		fallQ.delete();
		riseQ.delete();
		repeat (n) @(posedge clock);
		@(negedge clock);
		check(name, 0, fallQ.size());
		check("output idle high", 1, int'(pulseN === 1'b1));
	endtask : quiet

	// Main sequence
	initial begin
		int tf;
		int tr;
		int tc;
		repeat (6) @(posedge clock);
		@(negedge clock);
		reset_n = 1'b1;
		riseQ.delete();
		hostOn = 1'b1;
		quiet("pulses while strobed", 3000);
		@(negedge clock);
		hostOn = 1'b0;
		waitEdge(fallQ, 400, tf);
		checkIn("fall after last edge", lastEdge + toT[0], lastEdge + toT[0] + LAT, tf);
		repeat (50) @(negedge clock);
		gap = 32'h5;
		hostOn = 1'b1;
		repeat (30) @(negedge clock);
		hostOn = 1'b0;
		waitEdge(riseQ, 200, tr);
		check("pulse width", PULSE, tr - tf);
		waitEdge(fallQ, 400, tf);
		checkIn("fall after pulse end", tr + toT[0], tr + toT[0] + LAT, tf);
		waitEdge(riseQ, 200, tr);
		setSel(3'h4, tc);
		fallQ.delete();
		waitEdge(fallQ, 200, tf);
		tc = tc + SETTLE + stT[4] + toT[4];
		checkIn("fall after select change", tc, tc + LAT, tf);
		waitEdge(riseQ, 200, tr);
		check("pulse width short code", PULSE, tr - tf);
		waitEdge(fallQ, 50, tf);
		checkIn("short timeout restart", tr + toT[4], tr + toT[4] + LAT, tf);
		setSel(3'h3, tc);
		repeat (300) @(posedge clock);
		quiet("pulses while disabled", 1500);
		setSel(3'h0, tc);
		waitEdge(fallQ, 800, tf);
		tc = tc + SETTLE + stT[0] + toT[0];
		checkIn("fall after enable", tc, tc + LAT, tf);
		waitEdge(riseQ, 200, tr);
		check("pulse width after enable", PULSE, tr - tf);
		setSel(3'h3, tc);
		repeat (200) @(posedge clock);
		setSel(3'h5, tc);
		quiet("pulses awaiting first edge", 2000);
		wrapUp();
	end
endmodule : test_pin_selectable_watchdog_supervisor
